// ---- acs_pkg.sv ----
// package: register map, field layout and timing counts of the sequencer
`default_nettype none
package acs_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] ACS_CTRL_OFS   = 8'h00;
  localparam logic [7:0] ACS_SEL_OFS    = 8'h04;
  localparam logic [7:0] ACS_ACTIVE_OFS = 8'h08;
  localparam logic [7:0] ACS_RESULT_OFS = 8'h0C;
  // control/status field positions
  localparam int ACS_EN_BIT    = 0;
  localparam int ACS_START_BIT = 1;
  localparam int ACS_AUTO_BIT  = 2;
  localparam int ACS_FREE_BIT  = 3;
  localparam int ACS_DONE_BIT  = 4;
  localparam int ACS_HS_BIT    = 5;
  localparam int ACS_PS_LSB    = 6;
  localparam int ACS_PS_W      = 3;
  localparam int ACS_INV_BIT   = 9;
  localparam int ACS_HALF_BIT  = 8;
  // selection field layout
  localparam int ACS_CH_W  = 6;
  localparam int ACS_REF_W = 2;
  localparam int ACS_RES_W = 10;
  // reference codes
  localparam logic [1:0] ACS_REF_EXT    = 2'h0;
  localparam logic [1:0] ACS_REF_SUPPLY = 2'h1;
  localparam logic [1:0] ACS_REF_INT    = 2'h3;
  // channel decode: differential group and temperature sensor
  localparam logic [1:0] ACS_DIFF_TOP = 2'h1;
  localparam logic [5:0] ACS_TEMP_CH  = 6'h27;
  // conversion lengths and sample and hold points in converter clock cycles, reset prescaler select
  localparam logic [4:0] ACS_LEN_NORMAL = 5'h0D;
  localparam logic [4:0] ACS_LEN_DIFF   = 5'h0E;
  localparam logic [4:0] ACS_LEN_FIRST  = 5'h19;
  localparam logic [4:0] ACS_SH_NORMAL  = 5'h01;
  localparam logic [4:0] ACS_SH_FIRST   = 5'h0D;
  localparam logic [2:0] ACS_PS_RESET   = 3'h1;

  typedef enum logic [1:0] {
    ACS_IDLE = 2'b01,
    ACS_CONV = 2'b10
  } acs_state_e;

  typedef struct packed {
    logic [ACS_CH_W-1:0]  channel_select;
    logic [ACS_REF_W-1:0] reference_select;
  } acs_sel_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } acs_bus_s;

  typedef struct packed {
    acs_sel_s            sel;
    logic [2:0]          ref_onehot;
    logic                temp_sensor_en;
    logic                high_speed_mode_bit;
    logic                conv_active;
    logic                sample_hold;
    logic                conv_done;
  } acs_core_s;
endpackage
`default_nettype wire

// ---- acs_sequencer.sv ----
// converter control: prescaler, conversion timing, selection buffering
//
// How it works
// - free running differential restarts take 14 cycles
// - trigger resets prescaler; such differential result invalid unless first after enable
// - selection writes land in holding register, followed
// - selection frozen during conversion, released last cycle
// - written start begins at next converter clock
// - high speed bit leaves settling timing unchanged
// - free running restart takes channel from holding register
// - reference chooses supply, internal or external pin
// - temperature code enables sensor while converter enabled
// - differential start aligns to half rate clock
// - start bit reads one while converting
// - normal 13 cycles, first after enable extended
`default_nettype none
module acs_sequencer
  import acs_pkg::*;
#(
  parameter int PS_W = 7
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // register port
  input  wire logic [7:0]           addr,
  input  wire logic [31:0]          wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic [31:0]               rdata,
  // trigger pin
  input  wire logic                 trigger_pin,
  // analog core
  input  wire logic [ACS_RES_W-1:0] core_result,
  output acs_pkg::acs_core_s        core
);
  import acs_pkg::*;

  initial begin
    if (PS_W < 1 || PS_W > 7) begin
      $error("acs_sequencer: PS_W must be 1..7");
    end
  end

  typedef struct packed {
    acs_state_e           state;
    logic                 converter_enable;
    logic                 conversion_start_bit;
    logic                 start_pending;
    logic                 auto_trigger_enable;
    logic                 free_run;
    logic                 conversion_complete_flag;
    logic                 high_speed_mode_bit;
    logic [ACS_PS_W-1:0]  ps_sel;
    logic                 result_invalid;
    logic                 first_pending;
    logic                 cur_extended;
    logic                 cur_auto;
    // the running conversion samples a differential pair
    logic                 cur_diff;
    logic                 reset_since_enable;
    acs_sel_s             hold;
    acs_sel_s             active;
    logic                 locked;
    logic [PS_W-1:0]      ps_cnt;
    logic                 half_rate_sync_clock;
    logic [4:0]           cyc;
    logic [4:0]           len;
    logic                 sample_hold;
    logic                 conv_done;
    logic [ACS_RES_W-1:0] result;
    logic [2:0]           trig_sync;
    logic [31:0]          rdata;
  } acs_regs_s;

  acs_regs_s r_reg;
  acs_regs_s r_next;

  logic            tick;
  logic [PS_W-1:0] ps_mask;
  logic            trig_edge;
  logic            ctrl_wr;
  logic            sel_wr;
  logic            is_diff;

  ////////////////////////////////////////////////////////////////////////////
  // converter clock enable and trigger edge
  always_comb begin
    // prescaler divides the clock by two to the power ps_sel
    ps_mask = PS_W'((32'h1 << r_reg.ps_sel) - 32'h1);
    tick = r_reg.converter_enable && ((r_reg.ps_cnt & ps_mask) == ps_mask);
    // second and third stages only; the first feeds the second alone
    trig_edge = r_reg.trig_sync[1] && !r_reg.trig_sync[2];
    ctrl_wr = wr && (addr == ACS_CTRL_OFS);
    sel_wr = wr && (addr == ACS_SEL_OFS);
    // differential group decode of the active selection
    is_diff = (r_reg.active.channel_select[5:4] == ACS_DIFF_TOP);
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    r_next = r_reg;
    r_next.trig_sync = {r_reg.trig_sync[1:0], trigger_pin};
    r_next.sample_hold = 1'b0;
    r_next.conv_done = 1'b0;

    // prescaler runs while enabled, held in reset otherwise
    if (!r_reg.converter_enable) begin
      r_next.ps_cnt = '0;
      r_next.half_rate_sync_clock = 1'b0;
    end else begin
      r_next.ps_cnt = r_reg.ps_cnt + PS_W'(1);
      if (tick) begin
        r_next.half_rate_sync_clock = !r_reg.half_rate_sync_clock;
      end
    end

    // selection follows the holding register unless locked
    if (sel_wr) begin
      r_next.hold = wdata[ACS_CH_W+ACS_REF_W-1:0];
    end
    if (!r_reg.locked) begin
      r_next.active = r_reg.hold;
    end

    // register writes
    if (ctrl_wr) begin
      r_next.converter_enable = wdata[ACS_EN_BIT];
      r_next.auto_trigger_enable = wdata[ACS_AUTO_BIT];
      r_next.free_run = wdata[ACS_FREE_BIT];
      // stored and passed to the core only; no timing depends on it
      r_next.high_speed_mode_bit = wdata[ACS_HS_BIT];
      r_next.ps_sel = wdata[ACS_PS_LSB +: ACS_PS_W];
      if (wdata[ACS_PS_LSB +: ACS_PS_W] == '0) begin
        r_next.ps_sel = ACS_PS_RESET;
      end
      if (wdata[ACS_DONE_BIT]) begin
        r_next.conversion_complete_flag = 1'b0;
      end
      if (wdata[ACS_EN_BIT] && !r_reg.converter_enable) begin
        r_next.first_pending = 1'b1;
        r_next.reset_since_enable = 1'b0;
      end
      if (wdata[ACS_EN_BIT] && wdata[ACS_START_BIT] &&
          !r_reg.conversion_start_bit) begin
        r_next.conversion_start_bit = 1'b1;
        r_next.start_pending = 1'b1;
      end
    end

    if (!r_next.converter_enable) begin
      r_next.state = ACS_IDLE;
      r_next.conversion_start_bit = 1'b0;
      r_next.start_pending = 1'b0;
      r_next.locked = 1'b0;
    end else begin
      case (r_reg.state)
        ACS_IDLE: begin
          // auto trigger edge restarts the prescaler and starts at once
          if (r_reg.auto_trigger_enable && !r_reg.free_run && trig_edge &&
              !r_reg.conversion_complete_flag && !r_reg.start_pending) begin
            r_next.ps_cnt = '0;
            r_next.half_rate_sync_clock = 1'b0;
            r_next.conversion_start_bit = 1'b1;
            r_next.state = ACS_CONV;
            r_next.locked = 1'b1;
            r_next.cyc = '0;
            r_next.cur_auto = 1'b1;
            r_next.cur_diff = is_diff;
            r_next.cur_extended = r_reg.first_pending;
            r_next.first_pending = 1'b0;
            r_next.reset_since_enable = 1'b1;
            r_next.len = r_reg.first_pending ? ACS_LEN_FIRST
                                             : ACS_LEN_NORMAL;
          end else if (r_reg.start_pending && tick) begin
            r_next.start_pending = 1'b0;
            r_next.state = ACS_CONV;
            r_next.locked = 1'b1;
            r_next.cyc = '0;
            r_next.cur_auto = 1'b0;
            r_next.cur_diff = is_diff;
            r_next.cur_extended = r_reg.first_pending;
            r_next.first_pending = 1'b0;
            if (r_reg.first_pending) begin
              r_next.len = ACS_LEN_FIRST;
            end else if (is_diff && r_reg.half_rate_sync_clock) begin
              r_next.len = ACS_LEN_DIFF;
            end else begin
              r_next.len = ACS_LEN_NORMAL;
            end
          end
        end
        ACS_CONV: begin
          if (tick) begin
            r_next.cyc = r_reg.cyc + 5'h01;
            if (r_reg.cyc == (r_reg.cur_extended ? ACS_SH_FIRST
                                                 : ACS_SH_NORMAL)) begin
              r_next.sample_hold = 1'b1;
            end
            // release the lock in the final converter cycle
            if (r_reg.cyc == r_reg.len - 5'h02) begin
              r_next.locked = 1'b0;
            end
            if (r_reg.cyc == r_reg.len - 5'h01) begin
              r_next.conv_done = 1'b1;
              r_next.conversion_complete_flag = 1'b1;
              r_next.result = core_result;
              // auto differential result needs an extended conversion
              r_next.result_invalid = r_reg.cur_diff && r_reg.cur_auto &&
                                      !r_reg.cur_extended;
              if (r_reg.auto_trigger_enable && r_reg.free_run) begin
                // restart with the selection latched at this point
                r_next.cyc = '0;
                r_next.locked = 1'b1;
                r_next.cur_extended = 1'b0;
                r_next.cur_auto = 1'b1;
                r_next.cur_diff = is_diff;
                r_next.len = is_diff ? ACS_LEN_DIFF
                                     : ACS_LEN_NORMAL;
              end else begin
                r_next.state = ACS_IDLE;
                r_next.conversion_start_bit = 1'b0;
              end
            end
          end
        end
        default: begin
          r_next.state = ACS_IDLE;
        end
      endcase
    end

    // read data, valid in the cycle after the strobe
    r_next.rdata = '0;
    if (rd) begin
      case (addr)
        ACS_CTRL_OFS: begin
          r_next.rdata[ACS_EN_BIT] = r_reg.converter_enable;
          r_next.rdata[ACS_START_BIT] = r_reg.conversion_start_bit;
          r_next.rdata[ACS_AUTO_BIT] = r_reg.auto_trigger_enable;
          r_next.rdata[ACS_FREE_BIT] = r_reg.free_run;
          r_next.rdata[ACS_DONE_BIT] = r_reg.conversion_complete_flag;
          r_next.rdata[ACS_HS_BIT] = r_reg.high_speed_mode_bit;
          r_next.rdata[ACS_PS_LSB +: ACS_PS_W] = r_reg.ps_sel;
          r_next.rdata[ACS_INV_BIT] = r_reg.result_invalid;
        end
        ACS_SEL_OFS: begin
          r_next.rdata[ACS_CH_W+ACS_REF_W-1:0] = r_reg.hold;
        end
        ACS_ACTIVE_OFS: begin
          r_next.rdata[ACS_CH_W+ACS_REF_W-1:0] = r_reg.active;
          r_next.rdata[ACS_HALF_BIT] = r_reg.half_rate_sync_clock;
        end
        ACS_RESULT_OFS: begin
          r_next.rdata[ACS_RES_W-1:0] = r_reg.result;
        end
        default: begin
          r_next.rdata = '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '{state: ACS_IDLE, ps_sel: ACS_PS_RESET, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs to the analog core
  always_comb begin
    rdata = r_reg.rdata;
    core.sel = r_reg.active;
    core.ref_onehot = {r_reg.active.reference_select == ACS_REF_INT,
                       r_reg.active.reference_select == ACS_REF_SUPPLY,
                       r_reg.active.reference_select == ACS_REF_EXT
                      };
    core.temp_sensor_en = r_reg.converter_enable &&
      (r_reg.active.channel_select == ACS_TEMP_CH);
    core.high_speed_mode_bit = r_reg.high_speed_mode_bit;
    core.conv_active = (r_reg.state == ACS_CONV);
    core.sample_hold = r_reg.sample_hold;
    core.conv_done = r_reg.conv_done;
  end
endmodule
`default_nettype wire

// ---- acs_chk_checker.sv ----
// checker: port level assertions for the sequencer
`default_nettype none
module acs_chk
  import acs_pkg::*;
#(
  parameter int PS_W = 7
) (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 rst,
  // register port
  input wire logic [7:0]           addr,
  input wire logic [31:0]          wdata,
  input wire logic                 wr,
  input wire logic                 rd,
  input wire logic [31:0]          rdata,
  // pins
  input wire logic                 trigger_pin,
  input wire logic [ACS_RES_W-1:0] core_result,
  input wire acs_pkg::acs_core_s   core
);
  logic [7:0] cnt_reg;
  logic [1:0] rs;
  assign rs = core.sel.reference_select;
  // cycles spent in the running conversion
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt_reg <= 8'h00;
    else if (!core.conv_active || core.conv_done) cnt_reg <= 8'h00;
    else cnt_reg <= cnt_reg + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  property p_onehot;
    core.ref_onehot == {rs == ACS_REF_INT, rs == ACS_REF_SUPPLY,
                        rs == ACS_REF_EXT};
  endproperty
  a_onehot: assert property (p_onehot) else $error("bad ref decode");
  property p_temp;
    core.temp_sensor_en |-> core.sel.channel_select == ACS_TEMP_CH;
  endproperty
  a_temp: assert property (p_temp) else $error("sensor on, other ch");
  property p_lock;
    $rose(core.conv_active) |=> $stable(core.sel)[*8];
  endproperty
  a_lock: assert property (p_lock) else $error("sel moved in conv");
  property p_done_pulse;
    core.conv_done |=> !core.conv_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("long done");
  property p_len;
    core.conv_done |-> cnt_reg >= 8'h18;
  endproperty
  a_len: assert property (p_len) else $error("conversion too short");
  property p_sh;
    core.sample_hold |-> core.conv_active;
  endproperty
  a_sh: assert property (p_sh) else $error("sample while idle");
  property p_hs;
    wr && addr == ACS_CTRL_OFS |=>
      core.high_speed_mode_bit == $past(wdata[ACS_HS_BIT]);
  endproperty
  a_hs: assert property (p_hs) else $error("speed bit not copied");
  property p_busy;
    rd && addr == ACS_CTRL_OFS && core.conv_active && !core.conv_done &&
      !$past(core.conv_done) |=> rdata[ACS_START_BIT];
  endproperty
  a_busy: assert property (p_busy) else $error("start bit low in conv");
  property p_follow;
    (wr && addr == ACS_SEL_OFS && !core.conv_active) ##1
      (!core.conv_active && !wr)[*2] |->
      core.sel == $past(wdata[7:0], 2);
  endproperty
  a_follow: assert property (p_follow) else $error("sel not followed");
endmodule
bind acs_sequencer acs_chk #(.PS_W(PS_W)) acs_chk_inst (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .trigger_pin(trigger_pin), .core_result(core_result),
  .core(core));
`default_nettype wire

// ---- acs_core_model.sv ----
// analog core model: samples the active selection at sample and hold
`default_nettype none
module acs_core_model
  import acs_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // sequencer side
  input  wire acs_pkg::acs_core_s   core,
  output logic [ACS_RES_W-1:0]      core_result
);
  // result encodes the channel and reference seen at sampling
  always_ff @(posedge clk or posedge rst) begin
    if (rst) core_result <= 10'h000;
    else if (core.sample_hold) core_result <= {2'h2, core.sel};
  end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// testbench: scenarios for the converter sequencer
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import acs_pkg::*;
  logic clk, rst, wr, rd, trig;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v;
  logic [9:0] res;
  acs_core_s core;
  int err_count, num_checks, cyc, pre, len;
  localparam logic [2:0] OH [4] = '{3'h1, 3'h2, 3'h0, 3'h4};
  // differential settling: 125 us at a 50 ns clock
  localparam int SETTLE_CYC = 2500;
  acs_sequencer acs_sequencer_inst (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .trigger_pin(trig),
    .core_result(res), .core(core));
  acs_core_model acs_core_model_inst (.clk(clk), .rst(rst), .core(core),
    .core_result(res));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      err_count++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (err_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: %h expected %h", $time, s, e);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // counts idle then active cycles up to the next done pulse
  task automatic meas;
    int i;
    pre = 0;
    len = 0;
    i = 0;
    do begin
      @(posedge clk);
      #1;
      if (core.conv_active === 1'b1) len++;
      else pre++;
      i++;
    end while (core.conv_done !== 1'b1 && i < 400);
  endtask
  task automatic trg;
    @(posedge clk);
    trig <= 1'b1;
    repeat (4) @(posedge clk);
    trig <= 1'b0;
  endtask
  task automatic t_reset;
    #1 chk(32'(core), 32'h20);
    rdr(8'h10);
    chk(v, 32'h0);
    rdr(ACS_CTRL_OFS);
    chk(v, 32'h40);
  endtask
  task automatic t_single;
    wrr(ACS_SEL_OFS, 32'h14);
    wrr(ACS_CTRL_OFS, 32'h41);
    wrr(ACS_CTRL_OFS, 32'h43);
    meas;
    chk(32'(pre < 3), 32'h1);
    chk(32'(len), 32'd50);
    rdr(ACS_CTRL_OFS);
    chk(v, 32'h51);
    rdr(ACS_RESULT_OFS);
    chk(v, 32'h214);
    wrr(ACS_CTRL_OFS, 32'h53);
    repeat (4) @(posedge clk);
    rdr(ACS_CTRL_OFS);
    chk(v, 32'h43);
    wrr(ACS_SEL_OFS, 32'h28);
    #1 chk(32'(core.sel), 32'h14);
    meas;
    chk(32'(core.sel), 32'h28);
    wrr(ACS_CTRL_OFS, 32'h53);
    meas;
    chk(32'(len), 32'd26);
    rdr(ACS_RESULT_OFS);
    chk(v, 32'h228);
  endtask
  task automatic t_free;
    wrr(ACS_CTRL_OFS, 32'h51);
    wrr(ACS_SEL_OFS, 32'h4A);
    repeat (SETTLE_CYC) @(posedge clk);
    wrr(ACS_CTRL_OFS, 32'h4F);
    meas;
    chk(32'(len == 27 || len == 29), 32'h1);
    wrr(ACS_SEL_OFS, 32'h16);
    meas;
    chk(32'(len), 32'd26);
    rdr(ACS_RESULT_OFS);
    chk(v, 32'h24A);
    meas;
    rdr(ACS_RESULT_OFS);
    chk(v, 32'h216);
    wrr(ACS_CTRL_OFS, 32'h50);
    #1 chk(32'(core.conv_active), 32'h0);
  endtask
  task automatic t_trig;
    wrr(ACS_SEL_OFS, 32'h4A);
    repeat (SETTLE_CYC) @(posedge clk);
    wrr(ACS_CTRL_OFS, 32'h45);
    trg;
    meas;
    rdr(ACS_CTRL_OFS);
    chk(v, 32'h55);
    wrr(ACS_CTRL_OFS, 32'h55);
    trg;
    meas;
    rdr(ACS_CTRL_OFS);
    chk(v, 32'h255);
    wrr(ACS_CTRL_OFS, 32'h50);
    wrr(ACS_CTRL_OFS, 32'h45);
    trg;
    meas;
    rdr(ACS_CTRL_OFS);
    chk(v, 32'h55);
  endtask
  task automatic t_sel;
    wrr(ACS_CTRL_OFS, 32'h71);
    for (int r = 0; r < 4; r++) begin
      wrr(ACS_SEL_OFS, {24'h0, 6'h27, 2'(r)});
      repeat (2) @(posedge clk);
      #1 chk(32'(core.ref_onehot), 32'(OH[r]));
      chk(32'(core.temp_sensor_en), 32'h1);
    end
    chk(32'(core.high_speed_mode_bit), 32'h1);
    wrr(ACS_CTRL_OFS, 32'h73);
    meas;
    wrr(ACS_CTRL_OFS, 32'h73);
    meas;
    rdr(ACS_RESULT_OFS);
    chk(v, 32'h29F);
    wrr(ACS_SEL_OFS, 32'h17);
    repeat (2) @(posedge clk);
    #1 chk(32'(core.temp_sensor_en), 32'h0);
    wrr(ACS_CTRL_OFS, 32'h73);
    repeat (4) @(posedge clk);
    wrr(ACS_SEL_OFS, 32'h9F);
    meas;
    rdr(ACS_RESULT_OFS);
    chk(v, 32'h217);
    wrr(ACS_CTRL_OFS, 32'h73);
    meas;
    rdr(ACS_RESULT_OFS);
    chk(v, 32'h29F);
  endtask
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    trig = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    err_count = 0;
    num_checks = 0;
    cyc = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_single;
    t_free;
    t_trig;
    t_sel;
    conclude;
  end
endmodule
`default_nettype wire
